// ### include/pmsf_pkg.sv
// package of constants for the power mode and supply-fail controller
// assumes a 25 MHz core clock and an 8 kHz ring clock sampled as an input
package pmsf_pkg;
	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h00;
	localparam logic [7:0] ADDR_POWER_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0c;
	localparam logic [7:0] ADDR_WAKE_PERIOD = 8'h10;
	localparam logic [7:0] ADDR_MODE = 8'h14;
	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int CK_IDLE = 0;
	localparam int CK_STOP = 1;
	localparam int CK_HIGH_VOLTAGE_REGULATOR_ENABLE = 2;
	localparam int CK_PERF = 3;
	localparam int PW_MONDIS = 0;
	localparam int PW_INTV_LO = 1;
	localparam int ST_WARN = 0;
	localparam int ST_WAKE = 1;
	localparam int ST_FLASHBLK = 2;
	localparam int ST_SUPRST = 3;
	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [31:0] RST_POWER_CTRL = 32'h0000_0001;
	localparam logic [15:0] RST_WAKE_PERIOD = 16'hffff;
	localparam logic [3:0] RST_MASK = 4'h0;
	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int XTAL_MHZ = 12;
	localparam int EXIT_XTAL_CYC = 20;
	// less than 20 crystal cycles, rounded down to core cycles
	localparam int EXIT_CORE_CYC = (EXIT_XTAL_CYC - 1) * CLK_MHZ / XTAL_MHZ;
	localparam int WARMUP_CYC = 4000;
	localparam int WARN_QUAL_CYC = 250;
	localparam int INTV_SHIFT_BASE = 11;
	localparam logic [15:0] BOOT_ADDR = 16'h8000;
	typedef enum logic [3:0] {
		PM_OFF = 4'h0,
		PM_PUMP3 = 4'h1,
		PM_PUMP2 = 4'h2,
		PM_RUN = 4'h3,
		PM_IDLE = 4'h4,
		PM_STOP = 4'h5,
		PM_WARM = 4'h6,
		PM_SFRST = 4'h7,
		PM_EXTRST = 4'h8
	} pmsf_state_e;
endpackage : pmsf_pkg

// ### core/pmsf_top.sv
// power mode, stop/idle control and supply-fail response
// assumes synchronous comparator inputs and a 1-cycle ring tick input
//
// Notes on behaviour
// - regulator on and performance set give full crystal clock, flash allowed
// - regulator on, performance clear: crystal over three, flash allowed
// - both clear gives green mode, divide by three, flash blocked
// - writing idle bit enters idle, clocks and monitor keep running
// - enabled interrupt ends idle and hardware clears the idle bit
// - stop halts CPU, keeps state, wakes on io, warning or reset
// - ring-clocked wake timer, 125us steps, expiry ends stop
// - monitor disable acts only in stop and resets to one
// - stop with monitor disabled makes no warning and no reset
// - after supply reset, sample always or every 2^11..2^13 ring ticks
// - each periodic sample powers detection two ring cycles; here a sample found low at its first ring tick powers it one
// - good sample plus third ring period, warm-up, restart at 8000h
// - pin or watchdog reset keeps analog on, exits under 20 crystal cycles
// - supply in warning band for qualification time sets flag and interrupt
// - below reset threshold: CPU reset, backup regulator, periodic monitor
// - below power-on threshold the device stays held in reset
// - power-up order ring and triple pump, then monitor, doubler, LDO and crystal together
// - stop warning with monitor on: regulator, crystal, exit after warm-up
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pmsf_top
	import pmsf_pkg::*;
#(
	parameter int WARMUP = WARMUP_CYC,
	parameter int WARN_QUAL = WARN_QUAL_CYC
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic RING_TICK,
	input wire logic ABOVE_POR,
	input wire logic ABOVE_RST,
	input wire logic ABOVE_WARN,
	input wire logic PUMP3_GOOD,
	input wire logic PUMP2_GOOD,
	input wire logic REG_GOOD,
	input wire logic EXT_RESET_REQ,
	input wire logic WDT_RESET_REQ,
	input wire logic IO_IRQ,
	input wire logic CPU_IRQ_ANY,
	input wire logic FLASH_PROG_REQ,
	output logic FLASH_PROG_OK,
	output logic [1:0] SYSCLK_DIV_SEL,
	output logic CPU_RESET,
	output logic CPU_HALT,
	output logic [15:0] CPU_START_ADDR,
	output logic RING_EN,
	output logic PUMP3_EN,
	output logic MONITOR_EN,
	output logic PUMP2_EN,
	output logic LDO_EN,
	output logic XTAL_EN,
	output logic BACKUP_REG_EN,
	output logic IRQ
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	pmsf_state_e state_ff, nxt_state;
	logic idle_ff, stop_ff, high_voltage_regulator_enable_ff, perf_ff, mondis_ff;
	logic [1:0] intv_ff;
	logic [15:0] wake_per_ff, wake_cnt_ff, nxt_wake_cnt;
	logic [3:0] status_ff, mask_ff, nxt_status;
	logic [13:0] ring_cnt_ff, nxt_ring_cnt;
	logic [1:0] samp_ff, nxt_samp;
	logic [15:0] tmr_ff, nxt_tmr;
	logic [15:0] qual_ff;
	logic sup_boot_ff;
	logic wake_warm_ff;
	logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic wstrb0_ff;

	// ------------------------------------------------------------------
	// register bus decode
	// ------------------------------------------------------------------
	wire do_write = aw_ok_ff && w_ok_ff && !bvalid_ff;
	wire do_read = S_AXI_ARVALID && !rvalid_ff;
	wire wr_ck = do_write && awaddr_ff == ADDR_CLOCK_CTRL;
	wire wr_pw = do_write && awaddr_ff == ADDR_POWER_CTRL;
	wire wr_mask = do_write && awaddr_ff == ADDR_MASK;
	wire wr_wake = do_write && awaddr_ff == ADDR_WAKE_PERIOD;
	wire rd_status = do_read && S_AXI_ARADDR == ADDR_STATUS;
	wire wr_hit = wr_ck | wr_pw | wr_mask | wr_wake |
		(awaddr_ff == ADDR_STATUS) | (awaddr_ff == ADDR_MODE);
	wire [7:0] ra = S_AXI_ARADDR;
	wire rd_hit = ra == ADDR_CLOCK_CTRL || ra == ADDR_POWER_CTRL ||
		ra == ADDR_STATUS || ra == ADDR_MASK || ra == ADDR_WAKE_PERIOD ||
		ra == ADDR_MODE;
	wire [31:0] ck_word = {28'h0, perf_ff, high_voltage_regulator_enable_ff, stop_ff, idle_ff};
	wire [31:0] pw_word = {29'h0, intv_ff, mondis_ff};
	wire [31:0] mode_word = {12'h0, CPU_START_ADDR, state_ff};
	wire [31:0] rd_word =
		ra == ADDR_CLOCK_CTRL ? ck_word :
		ra == ADDR_POWER_CTRL ? pw_word :
		ra == ADDR_STATUS ? {28'h0, status_ff} :
		ra == ADDR_MASK ? {28'h0, mask_ff} :
		ra == ADDR_WAKE_PERIOD ? {16'h0, wake_per_ff} :
		ra == ADDR_MODE ? mode_word : 32'h0;

	assign S_AXI_AWREADY = !aw_ok_ff;
	assign S_AXI_WREADY = !w_ok_ff;
	assign S_AXI_ARREADY = !rvalid_ff;
	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RDATA = rdata_ff;
	logic bslv_ff, rslv_ff;
	assign S_AXI_BRESP = bslv_ff ? 2'h2 : 2'h0;
	assign S_AXI_RRESP = rslv_ff ? 2'h2 : 2'h0;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			bslv_ff <= 1'b0;
			rslv_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb0_ff <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			if (S_AXI_AWVALID && !aw_ok_ff) begin
				aw_ok_ff <= 1'b1;
				awaddr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_ok_ff) begin
				w_ok_ff <= 1'b1;
				wdata_ff <= S_AXI_WDATA;
				wstrb0_ff <= S_AXI_WSTRB[0];
			end
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bslv_ff <= !wr_hit;
			end else if (bvalid_ff && S_AXI_BREADY) begin
				bvalid_ff <= 1'b0;
				aw_ok_ff <= 1'b0;
				w_ok_ff <= 1'b0;
			end
			if (do_read) begin
				rvalid_ff <= 1'b1;
				rdata_ff <= rd_word;
				rslv_ff <= !rd_hit;
			end else if (S_AXI_RREADY) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------------
	wire running = state_ff == PM_RUN || state_ff == PM_IDLE;
	wire in_stop = state_ff == PM_STOP;
	// low byte lane carries every control bit but the wake period, so only strobe 0 matters; wake period writes ignore the strobes
	wire wr_lane0 = wstrb0_ff;
	wire prog_allowed = high_voltage_regulator_enable_ff;
	assign FLASH_PROG_OK = prog_allowed && running && FLASH_PROG_REQ;
	// 00 full crystal, 01 crystal over three
	assign SYSCLK_DIV_SEL = (high_voltage_regulator_enable_ff && perf_ff) ? 2'h0 : 2'h1;
	wire flash_block_ev = FLASH_PROG_REQ && !prog_allowed && running;
	// monitor is gated only while stopped
	wire mon_live = !(in_stop && mondis_ff);
	wire band_warn = ABOVE_RST && !ABOVE_WARN;
	wire warn_qual = qual_ff >= 16'(WARN_QUAL);
	wire warn_ev = mon_live && band_warn && warn_qual && (running || in_stop)
		&& qual_ff == 16'(WARN_QUAL);
	wire sup_fail = !ABOVE_RST && mon_live && state_ff != PM_OFF
		&& state_ff != PM_SFRST;
	wire wake_exp = in_stop && wake_cnt_ff == 16'h0 && RING_TICK;
	wire [13:0] intv_len = 14'(1) << (INTV_SHIFT_BASE + int'(intv_ff) - 1);
	wire samp_slot = intv_ff == 2'h0 || ring_cnt_ff == 14'h0;
	wire ext_rst = EXT_RESET_REQ || WDT_RESET_REQ;

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr = tmr_ff;
		nxt_ring_cnt = ring_cnt_ff;
		nxt_samp = samp_ff;
		nxt_wake_cnt = wake_cnt_ff;
		if (tmr_ff != 16'h0)
			nxt_tmr = tmr_ff - 16'h1;
		case (state_ff)
		PM_OFF: begin
			if (ABOVE_POR && ABOVE_RST)
				nxt_state = PM_PUMP3;
		end
		PM_PUMP3: begin
			if (PUMP3_GOOD)
				nxt_state = PM_PUMP2;
		end
		PM_PUMP2: begin
			if (PUMP2_GOOD && REG_GOOD) begin
				nxt_state = PM_WARM;
				nxt_tmr = 16'(WARMUP);
			end
		end
		PM_RUN: begin
			if (wr_ck && wr_lane0 && wdata_ff[CK_STOP])
				nxt_state = PM_STOP;
			else if (wr_ck && wr_lane0 && wdata_ff[CK_IDLE])
				nxt_state = PM_IDLE;
		end
		PM_IDLE: begin
			if (CPU_IRQ_ANY)
				nxt_state = PM_RUN;
		end
		PM_STOP: begin
			if (RING_TICK)
				nxt_wake_cnt = wake_cnt_ff - 16'h1;
			if (IO_IRQ || wake_exp || warn_ev) begin
				nxt_state = PM_WARM;
				nxt_tmr = 16'(WARMUP);
			end
		end
		PM_WARM: begin
			if (tmr_ff == 16'h0)
				nxt_state = PM_RUN;
		end
		PM_SFRST: begin
			if (RING_TICK) begin
				nxt_ring_cnt = (ring_cnt_ff == 14'h0) ? intv_len - 14'h1
					: ring_cnt_ff - 14'h1;
				// two window cycles, then a third confirming period
				if (samp_slot || samp_ff != 2'h0)
					nxt_samp = ABOVE_RST ? samp_ff + 2'h1 : 2'h0;
				if (samp_ff == 2'h2 && ABOVE_RST) begin
					nxt_state = PM_PUMP3;
					nxt_samp = 2'h0;
				end
			end
		end
		PM_EXTRST: begin
			if (!ext_rst && tmr_ff == 16'h0)
				nxt_state = PM_RUN;
		end
		default: nxt_state = PM_OFF;
		endcase
		if (!ABOVE_POR)
			nxt_state = PM_OFF;
		else if (sup_fail) begin
			nxt_state = PM_SFRST;
			nxt_samp = 2'h0;
			nxt_ring_cnt = 14'h0;
		end else if (ext_rst && running) begin
			nxt_state = PM_EXTRST;
			nxt_tmr = 16'(EXIT_CORE_CYC);
		end
		if (state_ff != PM_STOP)
			nxt_wake_cnt = wake_per_ff;
	end

	// status events: set beats the read-clear
	always_comb begin
		nxt_status = rd_status ? 4'h0 : status_ff;
		if (warn_ev)
			nxt_status[ST_WARN] = 1'b1;
		if (wake_exp)
			nxt_status[ST_WAKE] = 1'b1;
		if (flash_block_ev)
			nxt_status[ST_FLASHBLK] = 1'b1;
		if (sup_fail)
			nxt_status[ST_SUPRST] = 1'b1;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_ff <= PM_OFF;
			tmr_ff <= 16'h0;
			ring_cnt_ff <= 14'h0;
			samp_ff <= 2'h0;
			wake_cnt_ff <= RST_WAKE_PERIOD;
			status_ff <= 4'h0;
			qual_ff <= 16'h0;
			sup_boot_ff <= 1'b0;
			wake_warm_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff <= nxt_tmr;
			ring_cnt_ff <= nxt_ring_cnt;
			samp_ff <= nxt_samp;
			wake_cnt_ff <= nxt_wake_cnt;
			status_ff <= nxt_status;
			// band must hold continuously before the flag sets
			qual_ff <= (band_warn && mon_live) ?
				(warn_qual ? qual_ff : qual_ff + 16'h1) : 16'h0;
			if (state_ff == PM_SFRST)
				sup_boot_ff <= 1'b1;
			else if (state_ff == PM_RUN)
				sup_boot_ff <= 1'b0;
			wake_warm_ff <= state_ff == PM_STOP ||
				(state_ff == PM_WARM && wake_warm_ff);
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			idle_ff <= 1'b0;
			stop_ff <= 1'b0;
			high_voltage_regulator_enable_ff <= 1'b0;
			perf_ff <= 1'b0;
			mondis_ff <= RST_POWER_CTRL[PW_MONDIS];
			intv_ff <= 2'h0;
			mask_ff <= RST_MASK;
			wake_per_ff <= RST_WAKE_PERIOD;
		end else begin
			if (wr_ck && wr_lane0) begin
				high_voltage_regulator_enable_ff <= wdata_ff[CK_HIGH_VOLTAGE_REGULATOR_ENABLE];
				perf_ff <= wdata_ff[CK_PERF];
			end
			// bits follow the mode; hardware clears them on exit
			idle_ff <= nxt_state == PM_IDLE;
			stop_ff <= nxt_state == PM_STOP;
			if (wr_pw && wr_lane0) begin
				mondis_ff <= wdata_ff[PW_MONDIS];
				intv_ff <= wdata_ff[PW_INTV_LO +: 2];
			end
			if (wr_mask && wr_lane0)
				mask_ff <= wdata_ff[3:0];
			if (wr_wake)
				wake_per_ff <= wdata_ff[15:0];
		end
	end

	// ------------------------------------------------------------------
	// analog enables and cpu controls
	// ------------------------------------------------------------------
	wire active_analog = state_ff == PM_PUMP2 || state_ff == PM_WARM ||
		running || state_ff == PM_EXTRST;
	assign RING_EN = state_ff != PM_OFF;
	assign PUMP3_EN = state_ff != PM_OFF && !in_stop;
	assign MONITOR_EN = (state_ff == PM_SFRST) ? (samp_slot || samp_ff != 0)
		: (state_ff != PM_OFF && state_ff != PM_PUMP3 && mon_live);
	assign PUMP2_EN = active_analog;
	assign LDO_EN = active_analog;
	assign XTAL_EN = active_analog;
	assign BACKUP_REG_EN = !(running || state_ff == PM_EXTRST);
	// a wake from stop warms up with the core halted, not reset, so that
	// its registers survive; a cold start warms up held in reset
	wire warm_hold = state_ff == PM_WARM && wake_warm_ff;
	assign CPU_RESET = !(running || in_stop || warm_hold);
	assign CPU_HALT = in_stop || state_ff == PM_IDLE || warm_hold;
	assign CPU_START_ADDR = sup_boot_ff ? BOOT_ADDR : 16'h0;
	assign IRQ = |(status_ff & mask_ff);
endmodule : pmsf_top

// ### verif/pmsf_chk.sv
// checker for the power mode and supply-fail controller
// sees only top-level ports; bound to pmsf_top below
`timescale 1ns/1ps
module pmsf_chk (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic ABOVE_POR,
	input wire logic ABOVE_RST,
	input wire logic EXT_RESET_REQ,
	input wire logic WDT_RESET_REQ,
	input wire logic CPU_IRQ_ANY,
	input wire logic CPU_RESET,
	input wire logic CPU_HALT,
	input wire logic RING_EN,
	input wire logic PUMP3_EN,
	input wire logic MONITOR_EN,
	input wire logic PUMP2_EN,
	input wire logic LDO_EN,
	input wire logic XTAL_EN,
	input wire logic BACKUP_REG_EN,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	property p_por;
		!ABOVE_POR |-> ##[1:2] CPU_RESET && !XTAL_EN && !MONITOR_EN;
	endproperty
	a_por: assert property (p_por) else $error("low supply not held");
	property p_brown;
		!ABOVE_RST && MONITOR_EN && !CPU_RESET |->
			##[1:2] CPU_RESET && BACKUP_REG_EN;
	endproperty
	a_brown: assert property (p_brown) else $error("no brownout reset");
	property p_bk_off;
		$fell(BACKUP_REG_EN) |-> PUMP2_EN && LDO_EN && XTAL_EN && MONITOR_EN;
	endproperty
	a_bk_off: assert property (p_bk_off) else $error("backup off early");
	property p_dbl;
		$rose(PUMP2_EN) |-> PUMP3_EN && RING_EN && MONITOR_EN;
	endproperty
	a_dbl: assert property (p_dbl) else $error("doubler out of order");
	property p_xtal;
		$rose(XTAL_EN) |-> LDO_EN && PUMP2_EN;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal before ldo");
	property p_pin;
		(EXT_RESET_REQ || WDT_RESET_REQ) && !CPU_RESET && !CPU_HALT |->
			##[1:2] CPU_RESET && XTAL_EN && LDO_EN && MONITOR_EN;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset wrong");
	property p_pin_exit;
		$fell(EXT_RESET_REQ || WDT_RESET_REQ) && XTAL_EN && ABOVE_RST |->
			##[1:41] !CPU_RESET;
	endproperty
	a_pin_exit: assert property (p_pin_exit) else $error("slow exit");
	property p_idle;
		CPU_HALT && !BACKUP_REG_EN && CPU_IRQ_ANY |-> ##[1:2] !CPU_HALT;
	endproperty
	a_idle: assert property (p_idle) else $error("idle not left");
	property p_mon_off;
		CPU_HALT && BACKUP_REG_EN && !MONITOR_EN && !ABOVE_RST && ABOVE_POR
			|=> !CPU_RESET;
	endproperty
	a_mon_off: assert property (p_mon_off) else $error("reset in stop");
	property p_rd;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
endmodule : pmsf_chk
bind pmsf_top pmsf_chk chk_i (.*);

// ### verif/pmsf_supply.sv
// model of the analog side: comparators, pumps, ring oscillator
// ring tick period is shortened; pumps report good 3 cycles after enable
`timescale 1ns/1ps
module pmsf_supply #(
	parameter int TICK = 16
) (
	input wire logic CORE_CLK,
	input wire logic [1:0] LVL,
	input wire logic PUMP3_EN,
	input wire logic PUMP2_EN,
	input wire logic LDO_EN,
	output logic RING_TICK,
	output logic ABOVE_POR,
	output logic ABOVE_RST,
	output logic ABOVE_WARN,
	output logic PUMP3_GOOD,
	output logic PUMP2_GOOD,
	output logic REG_GOOD
);
	int div_ff = 0;
	logic [2:0] p3_ff = 3'h0;
	logic [2:0] p2_ff = 3'h0;
	// levels: 0 below power-on, 1 below reset, 2 warning band, 3 good
	assign ABOVE_POR = LVL > 2'd0;
	assign ABOVE_RST = LVL > 2'd1;
	assign ABOVE_WARN = LVL > 2'd2;
	// the ring runs free and ignores the core reset
	assign RING_TICK = div_ff == 0;
	assign PUMP3_GOOD = p3_ff[2];
	assign PUMP2_GOOD = p2_ff[2];
	assign REG_GOOD = p2_ff[2] && LDO_EN;
	always_ff @(posedge CORE_CLK) begin
		div_ff <= (div_ff == TICK - 1) ? 0 : div_ff + 1;
		p3_ff <= PUMP3_EN ? {p3_ff[1:0], 1'b1} : 3'h0;
		p2_ff <= PUMP2_EN ? {p2_ff[1:0], 1'b1} : 3'h0;
	end
endmodule : pmsf_supply

// ### verif/pmsf_top_bench.sv
// self-checking bench for pmsf_top with the analog model
// short warm-up, qualification and ring period keep the run brief
`timescale 1ns/1ps
module pmsf_top_bench;
	import pmsf_pkg::*;
	localparam int WU = 10;
	localparam int WQ = 4;
	localparam int TK = 16;
	logic CORE_CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
	logic S_AXI_ARVALID, S_AXI_RREADY, EXT_RESET_REQ, WDT_RESET_REQ;
	logic IO_IRQ, CPU_IRQ_ANY, FLASH_PROG_REQ, RING_TICK, ABOVE_POR;
	logic ABOVE_RST, ABOVE_WARN, PUMP3_GOOD, PUMP2_GOOD, REG_GOOD;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
	logic S_AXI_RVALID, FLASH_PROG_OK, CPU_RESET, CPU_HALT, RING_EN;
	logic PUMP3_EN, MONITOR_EN, PUMP2_EN, LDO_EN, XTAL_EN, BACKUP_REG_EN, IRQ;
	logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_d;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, SYSCLK_DIV_SEL, LVL, rd_r;
	logic [15:0] CPU_START_ADDR;
	logic [7:0] ra[3] = '{ADDR_POWER_CTRL, ADDR_WAKE_PERIOD, ADDR_MASK};
	logic [31:0] rv[3] = '{RST_POWER_CTRL, 32'h0000ffff, 32'h0};
	int error_cnt = 0;
	int compares = 0;
	int n;
	int p;
	logic w;
	pmsf_top #(.WARMUP(WU), .WARN_QUAL(WQ)) uut (.*);
	pmsf_supply #(.TICK(TK)) ana (.*);
	task automatic tally_and_finish;
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// bounded wait; leaves the count of clock cycles in n
	task automatic wt(ref logic s, input logic v, input int lim);
		for (n = 1; n <= lim; n++) begin
			@(negedge CORE_CLK);
			if (s === v)
				return;
		end
		error_cnt++;
		$display("MISMATCH %0t wait expired", $time);
		tally_and_finish();
	endtask : wt
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		wt(S_AXI_AWREADY, 1'b1, 50);
		w = S_AXI_WREADY;
		@(posedge CORE_CLK);
		S_AXI_AWVALID <= 1'b0;
		if (!w) begin
			wt(S_AXI_WREADY, 1'b1, 50);
			@(posedge CORE_CLK);
		end
		S_AXI_WVALID <= 1'b0;
		wt(S_AXI_BVALID, 1'b1, 50);
		@(posedge CORE_CLK);
		S_AXI_BREADY <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge CORE_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		wt(S_AXI_ARREADY, 1'b1, 50);
		@(posedge CORE_CLK);
		S_AXI_ARVALID <= 1'b0;
		wt(S_AXI_RVALID, 1'b1, 50);
		rd_d = S_AXI_RDATA;
		rd_r = S_AXI_RRESP;
		@(posedge CORE_CLK);
		S_AXI_RREADY <= 1'b0;
	endtask : rd
	initial begin
		CORE_CLK = 1'b0;
		forever #20 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = 4'h0;
		{S_AXI_RREADY, EXT_RESET_REQ, WDT_RESET_REQ, IO_IRQ} = 4'h0;
		{CPU_IRQ_ANY, FLASH_PROG_REQ} = 2'h0;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		S_AXI_WSTRB = 4'hf;
		LVL = 2'd3;
		RST = 1'b1;
		n = $urandom(32'hdf13);
		repeat (3) @(posedge CORE_CLK);
		RST <= 1'b0;
		wt(CPU_RESET, 1'b0, 200);
		chk(BACKUP_REG_EN, 1'b0);
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(rd_d, rv[i]);
		end
		rd(8'h40);
		chk(rd_r, 2'b10);
		FLASH_PROG_REQ <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			if (m == 2)
				continue;
			wr(ADDR_CLOCK_CTRL, 32'(m) << CK_HIGH_VOLTAGE_REGULATOR_ENABLE);
			@(negedge CORE_CLK);
			chk(SYSCLK_DIV_SEL, (m == 3) ? 32'h0 : 32'h1);
			chk(FLASH_PROG_OK, m & 1);
		end
		rd(ADDR_STATUS);
		chk(rd_d[ST_FLASHBLK], 1'b1);
		FLASH_PROG_REQ <= 1'b0;
		rd(ADDR_STATUS);
		chk(rd_d[ST_FLASHBLK], 1'b0);
		wr(ADDR_CLOCK_CTRL, 32'h0000000d);
		@(negedge CORE_CLK);
		chk({CPU_HALT, XTAL_EN, MONITOR_EN}, 3'h7);
		@(posedge CORE_CLK);
		CPU_IRQ_ANY <= 1'b1;
		wt(CPU_HALT, 1'b0, 4);
		@(posedge CORE_CLK);
		CPU_IRQ_ANY <= 1'b0;
		rd(ADDR_CLOCK_CTRL);
		chk(rd_d[CK_IDLE], 1'b0);
		wr(ADDR_MASK, 32'h1);
		LVL <= 2'd2;
		repeat (WQ - 1) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk(IRQ, 1'b0);
		wt(IRQ, 1'b1, 10);
		chk(CPU_RESET | CPU_HALT, 1'b0);
		@(posedge CORE_CLK);
		LVL <= 2'd3;
		rd(ADDR_STATUS);
		chk(rd_d[ST_WARN], 1'b1);
		@(negedge CORE_CLK);
		chk(IRQ, 1'b0);
		p = 1 + $urandom % 4;
		wr(ADDR_WAKE_PERIOD, p);
		wr(ADDR_MASK, 32'h2);
		wr(ADDR_CLOCK_CTRL, 32'h0000000e);
		@(negedge CORE_CLK);
		chk({CPU_HALT, XTAL_EN, CPU_RESET}, 3'h4);
		wt(CPU_HALT, 1'b0, (p + 1) * TK + WU + 60);
		chk(n > (p - 1) * TK, 1'b1);
		chk(IRQ, 1'b1);
		rd(ADDR_STATUS);
		chk(rd_d[ST_WAKE], 1'b1);
		wr(ADDR_WAKE_PERIOD, 32'h0000ffff);
		wr(ADDR_CLOCK_CTRL, 32'h0000000e);
		LVL <= 2'd1;
		repeat (20) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk({CPU_HALT, CPU_RESET}, 2'h2);
		@(posedge CORE_CLK);
		LVL <= 2'd3;
		IO_IRQ <= 1'b1;
		wt(CPU_HALT, 1'b0, WU + 60);
		@(posedge CORE_CLK);
		IO_IRQ <= 1'b0;
		wr(ADDR_POWER_CTRL, 32'h0);
		wr(ADDR_CLOCK_CTRL, 32'h0000000e);
		LVL <= 2'd2;
		wt(CPU_HALT, 1'b0, WU + WQ + 60);
		chk(CPU_RESET, 1'b0);
		@(posedge CORE_CLK);
		LVL <= 2'd1;
		wt(CPU_RESET, 1'b1, 10);
		chk({BACKUP_REG_EN, XTAL_EN}, 2'h2);
		@(posedge CORE_CLK);
		LVL <= 2'd3;
		wt(CPU_RESET, 1'b0, 4 * TK + WU + 60);
		chk(n >= 2 * TK, 1'b1);
		chk(CPU_START_ADDR, 16'h8000);
		rd(ADDR_STATUS);
		chk(rd_d[ST_SUPRST], 1'b1);
		wr(ADDR_POWER_CTRL, 32'h0000_0002);
		LVL <= 2'd1;
		wt(CPU_RESET, 1'b1, 10);
		repeat (2 * TK) @(posedge CORE_CLK);
		LVL <= 2'd3;
		@(negedge CORE_CLK);
		chk(MONITOR_EN, 1'b0);
		wt(CPU_RESET, 1'b0, 2060 * TK + WU + 60);
		chk(n > 2000 * TK, 1'b1);
		for (int k = 0; k < 2; k++) begin
			@(posedge CORE_CLK);
			EXT_RESET_REQ <= (k == 0);
			WDT_RESET_REQ <= (k == 1);
			repeat (3) @(posedge CORE_CLK);
			@(negedge CORE_CLK);
			chk({CPU_RESET, XTAL_EN, MONITOR_EN}, 3'h7);
			@(posedge CORE_CLK);
			EXT_RESET_REQ <= 1'b0;
			WDT_RESET_REQ <= 1'b0;
			wt(CPU_RESET, 1'b0, 41);
		end
		@(posedge CORE_CLK);
		LVL <= 2'd0;
		repeat (2) @(negedge CORE_CLK);
		chk({CPU_RESET, XTAL_EN, LDO_EN}, 3'h4);
		tally_and_finish();
	end
endmodule : pmsf_top_bench
